// ### src/asm_matrix_top.sv
// switch matrix control: AXI4-Lite register bank, applied switch state and checks
//
// Overview of operation
// - every switch is open after reset until software connects one
// - grouped config fields drive each switch set as a group
// - four individual config words can open or close each switch alone
// - individual words change nothing while the source bit is clear
// - read-only status words report every switch open or closed
// - closed exc output cal switch joins excitation output to cal pin a
// - closed pos node cal switch joins excitation node to cal pin a
// - closed neg node cal switch joins tia input to cal pin b
// - closed tia cal switch joins tia input to cal pin b
// - individual config words are read-write at consecutive offsets
// - status words read-only, order exc, pos, neg, tia
// - grouped config bit 16 selects individual (1) or grouped (0) control
// - tia field: 1-7 one switch, 8 cal, 9 all, others open
// - grouped bits 17 and 18 directly close the two extra tia switches
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module asm_matrix_top #(
   parameter int ADDR_W = 16
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [asm_pkg::SW_W-1:0] exc_out_sw,
   output logic [asm_pkg::SW_W-1:0] pos_node_sw,
   output logic [asm_pkg::SW_W-1:0] neg_node_sw,
   output logic [asm_pkg::SW_W-1:0] tia_input_sw,
   output logic exc_out_to_cal_pin_a,
   output logic pos_node_to_cal_pin_a,
   output logic tia_in_to_cal_pin_b_neg,
   output logic tia_in_to_cal_pin_b
);
   import asm_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   asm_sw_if sw ();

   logic [31:0] grp_r, grp_nxt;
   logic [SW_W-1:0] ind_d_r, ind_p_r, ind_n_r, ind_t_r;
   logic [SW_W-1:0] ind_d_nxt, ind_p_nxt, ind_n_nxt, ind_t_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic commit;
   asm_reg_e wsel, rsel;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // maps a byte address to a register, unmapped or unaligned gives R_NONE
   function automatic asm_reg_e f_sel(input logic [ADDR_W-1:0] a);
      logic [15:0] o;
      o = 16'(a);
      if (ADDR_W > 16 && (a >> 16) != '0) begin
         return R_NONE;
      end
      unique case (o)
         OFS_GRP: return R_GRP;
         OFS_IND_D: return R_IND_D;
         OFS_IND_N: return R_IND_N;
         OFS_IND_P: return R_IND_P;
         OFS_IND_T: return R_IND_T;
         OFS_STA_D: return R_STA_D;
         OFS_STA_P: return R_STA_P;
         OFS_STA_N: return R_STA_N;
         OFS_STA_T: return R_STA_T;
         default: return R_NONE;
      endcase
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] f_merge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            v[8*i+:8] = d[8*i+:8];
         end
      end
      return v;
   endfunction

   assign wsel = f_sel(awaddr_r);
   assign rsel = f_sel(s_axi_araddr);
   assign commit = aw_hold_r && w_hold_r && !bvalid_r;

   // ------------------------------------------------------------
   // write channel and register file
   // ------------------------------------------------------------
   // address and data are taken in either order, the write lands once both are held
   always_comb begin
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      grp_nxt = grp_r;
      ind_d_nxt = ind_d_r;
      ind_p_nxt = ind_p_r;
      ind_n_nxt = ind_n_r;
      ind_t_nxt = ind_t_r;
      if (s_axi_awvalid && awready_r) begin
         awaddr_nxt = s_axi_awaddr;
         aw_hold_nxt = 1'b1;
      end
      if (s_axi_wvalid && wready_r) begin
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
         w_hold_nxt = 1'b1;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (commit) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         unique case (wsel)
            R_GRP: grp_nxt = f_merge(grp_r, wdata_r, wstrb_r) & GRP_MASK;
            R_IND_D: ind_d_nxt = SW_W'(f_merge(32'(ind_d_r), wdata_r, wstrb_r));
            R_IND_N: ind_n_nxt = SW_W'(f_merge(32'(ind_n_r), wdata_r, wstrb_r));
            R_IND_P: ind_p_nxt = SW_W'(f_merge(32'(ind_p_r), wdata_r, wstrb_r));
            R_IND_T: ind_t_nxt = SW_W'(f_merge(32'(ind_t_r), wdata_r, wstrb_r));
            R_STA_D, R_STA_P, R_STA_N, R_STA_T: bresp_nxt = RESP_OKAY;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      awready_nxt = !aw_hold_nxt && !bvalid_nxt;
      wready_nxt = !w_hold_nxt && !bvalid_nxt;
   end

   // write-side flip-flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         grp_r <= GRP_RST;
         ind_d_r <= SW_W'(IND_RST);
         ind_p_r <= SW_W'(IND_RST);
         ind_n_r <= SW_W'(IND_RST);
         ind_t_r <= SW_W'(IND_RST);
      end else begin
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         grp_r <= grp_nxt;
         ind_d_r <= ind_d_nxt;
         ind_p_r <= ind_p_nxt;
         ind_n_r <= ind_n_nxt;
         ind_t_r <= ind_t_nxt;
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   // one read at a time, answer one cycle after the address is taken
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         unique case (rsel)
            R_GRP: rdata_nxt = grp_r;
            R_IND_D: rdata_nxt = 32'(ind_d_r);
            R_IND_N: rdata_nxt = 32'(ind_n_r);
            R_IND_P: rdata_nxt = 32'(ind_p_r);
            R_IND_T: rdata_nxt = 32'(ind_t_r);
            R_STA_D: rdata_nxt = 32'(sw.sw_d);
            R_STA_P: rdata_nxt = 32'(sw.sw_p);
            R_STA_N: rdata_nxt = 32'(sw.sw_n);
            R_STA_T: rdata_nxt = 32'(sw.sw_t);
            default: begin
               rdata_nxt = '0;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
      arready_nxt = !rvalid_nxt;
   end

   // read-side flip-flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ------------------------------------------------------------
   // switch decode and applied state
   // ------------------------------------------------------------
   assign sw.grp = grp_r;
   assign sw.ind_d = ind_d_r;
   assign sw.ind_p = ind_p_r;
   assign sw.ind_n = ind_n_r;
   assign sw.ind_t = ind_t_r;

   asm_group_decode u_dec (
      .sw(sw.dec)
   );

   asm_switch_state u_state (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sw(sw.app)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign exc_out_sw = sw.sw_d;
   assign pos_node_sw = sw.sw_p;
   assign neg_node_sw = sw.sw_n;
   assign tia_input_sw = sw.sw_t;
   assign exc_out_to_cal_pin_a = sw.exc_cal_a;
   assign pos_node_to_cal_pin_a = sw.pos_cal_a;
   assign tia_in_to_cal_pin_b_neg = sw.neg_cal_b;
   assign tia_in_to_cal_pin_b = sw.tia_cal_b;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_grp_write;
      commit && wsel == R_GRP;
   endsequence

   sequence s_ind_d_write;
      commit && wsel == R_IND_D;
   endsequence

   property p_open_at_start;
      $rose(reset_n) |-> exc_out_sw == '0 && tia_input_sw == '0;
   endproperty
   a_open_at_start: assert property (p_open_at_start) else $error("switch closed at reset");

   property p_src_sel;
      s_grp_write ##1 1'b1 |-> sw.grp[SRC_BIT] == $past(wdata_r[SRC_BIT], 1)
         || !$past(wstrb_r[2], 1);
   endproperty
   a_src_sel: assert property (p_src_sel) else $error("source bit not stored");

   property p_group_ctl;
      !grp_r[SRC_BIT] ##1 !grp_r[SRC_BIT] |-> exc_out_sw == $past(sw.dec_d);
   endproperty
   a_group_ctl: assert property (p_group_ctl) else $error("group field not applied");

   property p_ind_ctl;
      grp_r[SRC_BIT] |=> pos_node_sw == $past(ind_p_r);
   endproperty
   a_ind_ctl: assert property (p_ind_ctl) else $error("individual word not applied");

   property p_ind_blocked;
      s_ind_d_write ##0 !grp_r[SRC_BIT] ##1 !grp_r[SRC_BIT] ##1 !grp_r[SRC_BIT]
         |-> exc_out_sw == $past(exc_out_sw, 2) || $changed(grp_r);
   endproperty
   a_ind_blocked: assert property (p_ind_blocked) else $error("switch moved with source clear");

   property p_tia_all;
      !grp_r[SRC_BIT] && grp_r[T_LSB+:4] == CODE_ALL |=> tia_input_sw[7:0] == 8'hFF;
   endproperty
   a_tia_all: assert property (p_tia_all) else $error("tia all-closed code wrong");

   property p_tia_open;
      !grp_r[SRC_BIT] && grp_r[T_LSB+:4] > CODE_ALL |=> tia_input_sw[7:0] == 8'h00;
   endproperty
   a_tia_open: assert property (p_tia_open) else $error("tia open code wrong");

   property p_tia_extra;
      !grp_r[SRC_BIT] |=> tia_input_sw[T_EXT_A] == $past(grp_r[T9_BIT])
         && tia_input_sw[T_EXT_B] == $past(grp_r[T10_BIT]);
   endproperty
   a_tia_extra: assert property (p_tia_extra) else $error("extra tia switch wrong");

   property p_cal_link;
      exc_out_to_cal_pin_a == exc_out_sw[CAL_D] && tia_in_to_cal_pin_b == tia_input_sw[CAL_T]
         && pos_node_to_cal_pin_a == pos_node_sw[CAL_P]
         && tia_in_to_cal_pin_b_neg == neg_node_sw[CAL_N];
   endproperty
   a_cal_link: assert property (p_cal_link) else $error("cal pin link mismatch");

   property p_status_read;
      s_axi_arvalid && arready_r && rsel == R_STA_T
         |=> s_axi_rvalid && s_axi_rdata == 32'($past(tia_input_sw));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_status_ro;
      commit && wsel inside {R_STA_D, R_STA_P, R_STA_N, R_STA_T}
         |=> grp_r == $past(grp_r) && ind_d_r == $past(ind_d_r) && ind_t_r == $past(ind_t_r);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write changed state");

endmodule

// ### pkg/asm_pkg.sv
// package: offsets, field layout, reset values and codes of the switch matrix control
package asm_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OFS_GRP = 16'h200C;
   localparam logic [15:0] OFS_IND_D = 16'h2150;
   localparam logic [15:0] OFS_IND_N = 16'h2154;
   localparam logic [15:0] OFS_IND_P = 16'h2158;
   localparam logic [15:0] OFS_IND_T = 16'h215C;
   localparam logic [15:0] OFS_STA_D = 16'h21B0;
   localparam logic [15:0] OFS_STA_P = 16'h21B4;
   localparam logic [15:0] OFS_STA_N = 16'h21B8;
   localparam logic [15:0] OFS_STA_T = 16'h21BC;

   // ------------------------------------------------------------
   // reset values and writable masks
   // ------------------------------------------------------------
   localparam logic [31:0] GRP_RST = 32'h0000FFFF;
   localparam logic [31:0] GRP_MASK = 32'h0007FFFF;
   localparam logic [31:0] IND_RST = 32'h00000000;
   localparam int SW_W = 16;

   // ------------------------------------------------------------
   // grouped config field positions
   // ------------------------------------------------------------
   localparam int D_LSB = 0;
   localparam int P_LSB = 4;
   localparam int N_LSB = 8;
   localparam int T_LSB = 12;
   localparam int SRC_BIT = 16;
   localparam int T9_BIT = 17;
   localparam int T10_BIT = 18;

   // ------------------------------------------------------------
   // switch positions inside each 16-bit set
   // ------------------------------------------------------------
   localparam int CAL_D = 0;
   localparam int CAL_T = 0;
   localparam int CAL_P = 1;
   localparam int CAL_N = 10;
   localparam int LDO_PA = 0;
   localparam int LDO_PB = 14;
   localparam int LDO_NA = 0;
   localparam int LDO_NB = 11;
   localparam int T_EXT_A = 9;
   localparam int T_EXT_B = 10;

   // ------------------------------------------------------------
   // group codes and bus answers
   // ------------------------------------------------------------
   localparam logic [3:0] CODE_CAL = 4'h8;
   localparam logic [3:0] CODE_ALL = 4'h9;
   localparam logic [3:0] CODE_OPEN = 4'hF;
   localparam logic [3:0] CODE_NEG_TIE_B = 4'hB;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      R_GRP, R_IND_D, R_IND_N, R_IND_P, R_IND_T,
      R_STA_D, R_STA_P, R_STA_N, R_STA_T, R_NONE
   } asm_reg_e;

endpackage

// ### pkg/asm_sw_if.sv
// interface: configuration and applied switch state between matrix modules
interface asm_sw_if;
   import asm_pkg::*;
   logic [31:0] grp;
   logic [SW_W-1:0] ind_d, ind_p, ind_n, ind_t;
   logic [SW_W-1:0] dec_d, dec_p, dec_n, dec_t;
   logic [SW_W-1:0] sw_d, sw_p, sw_n, sw_t;
   logic exc_cal_a, pos_cal_a, neg_cal_b, tia_cal_b;

   modport dec (input grp, output dec_d, dec_p, dec_n, dec_t);
   modport app (input grp, ind_d, ind_p, ind_n, ind_t, dec_d, dec_p, dec_n, dec_t,
                output sw_d, sw_p, sw_n, sw_t, exc_cal_a, pos_cal_a, neg_cal_b, tia_cal_b);
endinterface

// ### src/asm_group_decode.sv
// group decoder: turns grouped config fields into switch sets
module asm_group_decode (
   asm_sw_if.dec sw
);
   import asm_pkg::*;

   // ------------------------------------------------------------
   // decode functions
   // ------------------------------------------------------------
   // exc output and tia sets: 1..7 one switch, 8 cal, 9 all, rest open
   function automatic logic [SW_W-1:0] f_dt(input logic [3:0] code);
      logic [SW_W-1:0] v;
      v = '0;
      if (code >= 4'h1 && code <= 4'h7) begin
         v[code] = 1'b1;
      end else if (code == CODE_CAL) begin
         v[CAL_T] = 1'b1;
      end else if (code == CODE_ALL) begin
         v[7:0] = 8'hFF;
      end
      return v;
   endfunction

   // pos and neg sets: code picks one switch, open code opens all
   function automatic logic [SW_W-1:0] f_pn(input logic [3:0] code, input logic neg);
      logic [SW_W-1:0] v;
      v = '0;
      if (code != CODE_OPEN) begin
         if (neg && code >= CODE_NEG_TIE_B) begin
            v[LDO_NB] = 1'b1;
         end else begin
            v[code] = 1'b1;
         end
      end
      return v;
   endfunction

   // ------------------------------------------------------------
   // group outputs
   // ------------------------------------------------------------
   always_comb begin
      sw.dec_d = f_dt(sw.grp[D_LSB+:4]);
      sw.dec_p = f_pn(sw.grp[P_LSB+:4], 1'b0);
      sw.dec_n = f_pn(sw.grp[N_LSB+:4], 1'b1);
      sw.dec_t = f_dt(sw.grp[T_LSB+:4]);
      sw.dec_t[T_EXT_A] = sw.grp[T9_BIT];
      sw.dec_t[T_EXT_B] = sw.grp[T10_BIT];
   end
endmodule

// ### src/asm_switch_state.sv
// applied switch state: source select and the switch flip-flops
module asm_switch_state (
   input wire logic ref_clk,
   input wire logic reset_n,
   asm_sw_if.app sw
);
   import asm_pkg::*;

   logic [SW_W-1:0] d_nxt, p_nxt, n_nxt, t_nxt;
   logic [SW_W-1:0] d_r, p_r, n_r, t_r;
   logic [3:0] link_nxt, link_r;

   // ------------------------------------------------------------
   // source select
   // ------------------------------------------------------------
   // individual words only act while the source bit is set
   always_comb begin
      if (sw.grp[SRC_BIT]) begin
         d_nxt = sw.ind_d;
         p_nxt = sw.ind_p;
         n_nxt = sw.ind_n;
         t_nxt = sw.ind_t;
      end else begin
         d_nxt = sw.dec_d;
         p_nxt = sw.dec_p;
         n_nxt = sw.dec_n;
         t_nxt = sw.dec_t;
      end
      link_nxt = {t_nxt[CAL_T], n_nxt[CAL_N], p_nxt[CAL_P], d_nxt[CAL_D]};
   end

   // all switches open from reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         d_r <= '0;
         p_r <= '0;
         n_r <= '0;
         t_r <= '0;
         link_r <= '0;
      end else begin
         d_r <= d_nxt;
         p_r <= p_nxt;
         n_r <= n_nxt;
         t_r <= t_nxt;
         link_r <= link_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sw.sw_d = d_r;
   assign sw.sw_p = p_r;
   assign sw.sw_n = n_r;
   assign sw.sw_t = t_r;
   assign sw.exc_cal_a = link_r[0];
   assign sw.pos_cal_a = link_r[1];
   assign sw.neg_cal_b = link_r[2];
   assign sw.tia_cal_b = link_r[3];
endmodule

// ### verification/asm_cal_pin_model.sv
// far-side model: calibration resistor pins and the nodes joined to them
module asm_cal_pin_model (
   input wire logic exc_a,
   input wire logic pos_a,
   input wire logic neg_b,
   input wire logic tia_b,
   output logic [1:0] load_a,
   output logic [1:0] load_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // count the amplifier nodes that each resistor pin sees
   assign load_a = 2'(exc_a) + 2'(pos_a);
   assign load_b = 2'(neg_b) + 2'(tia_b);
endmodule

// ### verification/tb_top.sv
// testbench: register bus, group decode, individual control and status of the matrix
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import asm_pkg::*;
   logic ref_clk = 0, reset_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [15:0] awa = 0, ara = 0, sd, sp, sn, st;
   logic [31:0] wd = 0, rdt;
   logic awr, wr_rdy, bv, arr, rv, c_exc, c_pos, c_neg, c_tia;
   logic [1:0] br, rr, la, lb;
   logic [3:0] ws = 4'hF;
   int n_errors = 0, checked = 0;
   // ------------------------------------------------------------
   // design, far-side model and clock
   // ------------------------------------------------------------
   asm_matrix_top asm_matrix_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .exc_out_sw(sd), .pos_node_sw(sp), .neg_node_sw(sn),
      .tia_input_sw(st), .exc_out_to_cal_pin_a(c_exc), .pos_node_to_cal_pin_a(c_pos),
      .tia_in_to_cal_pin_b_neg(c_neg), .tia_in_to_cal_pin_b(c_tia));
   asm_cal_pin_model asm_cal_pin_model_inst (.exc_a(c_exc), .pos_a(c_pos), .neg_b(c_neg),
      .tia_b(c_tia), .load_a(la), .load_b(lb));
   // 250 MHz clock
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one write; every channel held until its own handshake edge
   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
      end while (!bv && n < 50);
      r = br;
      bry <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (arv && arr) arv <= 1'b0;
      end while (!rv && n < 50);
      d = rdt;
      r = rr;
      rry <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   // read a word and compare data and response
   task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(r, er)
      `CHK(d, e)
   endtask
   // write expecting an answer code
   task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      wr(a, d, r);
      `CHK(r, er)
   endtask
   // switch outputs and status words against one expectation
   task automatic swc(input logic [15:0] d, p, n, t);
      repeat (2) @(posedge ref_clk);
      `CHK({sd, sp, sn, st}, {d, p, n, t})
      rdc(OFS_STA_D, {16'h0000, d}, RESP_OKAY);
      rdc(OFS_STA_P, {16'h0000, p}, RESP_OKAY);
      rdc(OFS_STA_N, {16'h0000, n}, RESP_OKAY);
      rdc(OFS_STA_T, {16'h0000, t}, RESP_OKAY);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      swc(16'h0, 16'h0, 16'h0, 16'h0);
      rdc(OFS_GRP, GRP_RST, RESP_OKAY);
      rdc(OFS_IND_D, IND_RST, RESP_OKAY);
      rdc(OFS_IND_T, IND_RST, RESP_OKAY);
   endtask
   // every tia group code, then the two extra switches and the exc cal code
   task automatic t_group;
      logic [15:0] e;
      for (int k = 0; k < 16; k++) begin
         wrc(OFS_GRP, 32'h00000FFF | (k << 12), RESP_OKAY);
         e = (k >= 1 && k <= 7) ? 16'h0001 << k : (k == 8) ? 16'h0001 << CAL_T :
             (k == 9) ? 16'h00FF : 16'h0000;
         swc(16'h0, 16'h0, 16'h0, e);
         `CHK(c_tia, 1'(k == 8 || k == 9))
      end
      wrc(OFS_GRP, 32'hFFF6FFFF, RESP_OKAY);
      rdc(OFS_GRP, 32'h0006FFFF, RESP_OKAY);
      swc(16'h0, 16'h0, 16'h0, (16'h0001 << T_EXT_A) | (16'h0001 << T_EXT_B));
      wrc(OFS_GRP, 32'h0000FFF8, RESP_OKAY);
      swc(16'h0001 << CAL_D, 16'h0, 16'h0, 16'h0);
      `CHK({c_exc, la}, 3'h5)
      // byte strobe: only the neg and tia byte lands, neg code picks tie b
      ws <= 4'h2;
      wrc(OFS_GRP, 32'hFFFF0BFF, RESP_OKAY);
      ws <= 4'hF;
      rdc(OFS_GRP, 32'h00000BF8, RESP_OKAY);
      swc(16'h0001, 16'h0, 16'h0800, 16'h0);
      // exc all-closed code and pos tie a code
      wrc(OFS_GRP, 32'h0000FF09, RESP_OKAY);
      swc(16'h00FF, 16'h0001, 16'h0, 16'h0);
   endtask
   // individual words first, source bit second, then refusals
   task automatic t_indiv;
      logic [15:0] p, n;
      p = (16'h0001 << LDO_PA) | (16'h0001 << LDO_PB) | (16'h0001 << CAL_P);
      n = (16'h0001 << LDO_NA) | (16'h0001 << LDO_NB) | (16'h0001 << CAL_N);
      wrc(OFS_GRP, GRP_RST, RESP_OKAY);
      wrc(OFS_IND_D, 32'hFFFF0002, RESP_OKAY);
      wrc(OFS_IND_N, {16'hFFFF, n}, RESP_OKAY);
      wrc(OFS_IND_P, {16'hFFFF, p}, RESP_OKAY);
      wrc(OFS_IND_T, 32'hFFFF0001, RESP_OKAY);
      rdc(OFS_IND_P, {16'h0000, p}, RESP_OKAY);
      swc(16'h0, 16'h0, 16'h0, 16'h0);
      wrc(OFS_GRP, 32'h0001FFFF, RESP_OKAY);
      swc(16'h0002, p, n, 16'h0001);
      `CHK({c_pos, c_neg, c_tia, la, lb}, 7'h76)
      wrc(OFS_STA_T, 32'h0000FFFF, RESP_OKAY);
      wrc(16'h2000, 32'h00000000, RESP_SLVERR);
      rdc(16'h2004, 32'h0, RESP_SLVERR);
      swc(16'h0002, p, n, 16'h0001);
      wrc(OFS_GRP, GRP_RST, RESP_OKAY);
      swc(16'h0, 16'h0, 16'h0, 16'h0);
   endtask
   // reset for three cycles, then the scenarios
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_group();
      t_indiv();
      report_and_stop();
   end
endmodule
